// [design/lie_evt_regs.svh]
// Register map, field positions and timing constants of the interrupt event block.
// Assumes inclusion by bare name from the package and the block's single module.
//
// What this block does
// R1: Hardware-sourced event bits set on the source's rising edge and stay set.
// R2: Writing 1 through the set port forces that event bit to 1.
// R3: Only writing 1 through the clear port returns an event bit to 0.
// R4: Reads of either port return event bits ANDed with the mask.
// R5: Bits 31 and 28 read as 0 and ignore writes.
// R6: Bit 30 sets when an enabled general-purpose input asserts.
// R7: Bit 29 has no hardware source; software sets and clears it.
// R8: Bit 27 sets on pending receive data, busy responder or tardy acknowledge, if enabled.
// R9: Bit 26 sets on a transceiver byte; byte readable at bits 23-16.
// R10: As cycle root, bit 25 sets if start-to-gap exceeds 125 us.
// R11: The overlong-cycle event also clears the cycle root role bit.
// R12: Bit 24 sets when an error halts a subunit, such as a dead context.
// R13: While bit 24 is set, normal events of the failed contexts are blocked.
// R14: Register mixes set/clear+update, set/clear, update-only and fixed read-only bits; no bit here is update-only, both ports reach every hardware bit.
// R15: Interrupt output is high while any event AND mask bit is 1.
// R16: A hardware set wins over a software clear in the same cycle.
`ifndef LIE_EVT_REGS_SVH
`define LIE_EVT_REGS_SVH

`define LIE_OFS_EVT_SET    8'h80
`define LIE_OFS_EVT_CLR    8'h84
`define LIE_OFS_EVT_MASK   8'h88
`define LIE_OFS_EVT_RAW    8'h8c
`define LIE_OFS_CTRL       8'h90
`define LIE_OFS_XCVR       8'h94

`define LIE_BIT_GP_INPUT   30
`define LIE_BIT_SOFT       29
`define LIE_BIT_LATE_ACK   27
`define LIE_BIT_XCVR_BYTE  26
`define LIE_BIT_OVERLONG   25
`define LIE_BIT_FATAL      24
`define LIE_EVT_IMPL       32'h6f00_0000
`define LIE_EVT_HW         32'h4f00_0000

`define LIE_CTRL_LATE_ACK  0
`define LIE_CTRL_GP_A      1
`define LIE_CTRL_GP_B      2
`define LIE_CTRL_ROOT      3
`define LIE_CTRL_RESET     4'h0
`define LIE_XCVR_LSB       16

`define LIE_CLK_PERIOD_NS  10
`define LIE_CYCLE_LIMIT_NS 125000
`define LIE_NUM_CTX        4
`define LIE_NUM_GP         2

`endif

// [design/lie_pkg.sv]
// Types shared by the interrupt event block: source bundle and timer states.
// Assumes lie_evt_regs.svh is on the include path.
`include "lie_evt_regs.svh"

package lie_pkg;

  typedef struct packed {
    logic                      rx_fifo_pending;   // Receive data waits for the host
    logic                      resp_unit_busy;    // Physical response unit busy
    logic                      tardy_ack_sent;    // Tardy acknowledge sent
    logic                      xcvr_byte_valid;   // Transceiver register byte arrived
    logic [7:0]                xcvr_byte;         // The byte itself
    logic                      cycle_start_tx;    // Start of sending a cycle start
    logic                      subaction_gap_end; // End of a subaction gap
    logic [`LIE_NUM_CTX-1:0]   ctx_dead;          // Per-context dead status
  } lie_src_s;

  typedef enum logic [0:0] {
    TMR_IDLE,
    TMR_RUN
  } lie_tmr_e;

endpackage

// [design/lie_evt.sv]
// Interrupt event register with set/clear ports, mask, control and overlong-cycle timer.
// Assumes an APB master on pclk; hardware sources are synchronous to pclk except gp pins.
// Lower event bits and their sources live outside this block.
`include "lie_evt_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module lie_evt
  import lie_pkg::*;
#(
  parameter int OVERLONG_CYC = `LIE_CYCLE_LIMIT_NS / `LIE_CLK_PERIOD_NS
)
(
  input  wire logic                    pclk,            // Controller clock
  input  wire logic                    presetn,         // Async reset, active low
  input  wire logic                    psel,            // APB select
  input  wire logic                    penable,         // APB access phase
  input  wire logic                    pwrite,          // APB direction
  input  wire logic [7:0]              paddr,           // APB byte address
  input  wire logic [31:0]             pwdata,          // APB write data
  output logic                         pready,          // APB ready
  output logic [31:0]                  prdata,          // APB read data
  output logic                         pslverr,         // APB error, unmapped address
  input  wire logic                    gp_input_a,      // General-purpose interrupt pin A
  input  wire logic                    gp_input_b,      // General-purpose interrupt pin B
  input  wire lie_src_s                src,             // Same-clock hardware sources
  output logic                         irq,             // Host interrupt, level
  output logic                         cycle_root_role, // Acting as cycle root
  output logic [`LIE_NUM_CTX-1:0]      ctx_evt_block    // Block normal events per context
);

  // Limit counts pclk cycles from the cycle start edge
  localparam logic [15:0] LIMIT = 16'(OVERLONG_CYC);

  // Register state
  logic [31:0]             evt_q;
  logic [31:0]             evt_d;
  logic [31:0]             mask_q;
  logic [3:0]              ctrl_q;
  logic [7:0]              xcvr_q;
  logic [`LIE_NUM_CTX-1:0] dead_ctx_q;

  // Edge detection history
  logic                    gp_lvl_q;
  logic                    late_lvl_q;
  logic                    xcvr_lvl_q;
  logic [`LIE_NUM_CTX-1:0] dead_lvl_q;

  // Pin synchronisers
  logic [1:0]              gp_pin;
  logic [2:0]              gp_sync_q [`LIE_NUM_GP];
  logic [1:0]              gp_pin_q;

  // Overlong timer
  lie_tmr_e                tmr_q;
  logic [15:0]             tmr_cnt_q;
  logic                    overlong;

  // Bus decode
  logic                    setup;
  logic                    wr_acc;
  logic                    wr_set;
  logic                    wr_clr;
  logic                    wr_mask;
  logic                    wr_ctrl;
  logic                    mapped;
  logic [31:0]             rd_val;

  // Hardware event levels and set vector
  logic                    gp_lvl;
  logic                    late_lvl;
  logic [`LIE_NUM_CTX-1:0] new_dead;
  logic [31:0]             hw_set;
  logic [31:0]             sw_set;
  logic [31:0]             sw_clr;

  // APB slave: read data captured in the setup phase
  // Writes to the read-only offsets are dropped without an error
  assign setup   = psel & ~penable;
  assign wr_acc  = psel & penable & pwrite;
  assign wr_set  = wr_acc & (paddr == `LIE_OFS_EVT_SET);
  assign wr_clr  = wr_acc & (paddr == `LIE_OFS_EVT_CLR);
  assign wr_mask = wr_acc & (paddr == `LIE_OFS_EVT_MASK);
  assign wr_ctrl = wr_acc & (paddr == `LIE_OFS_CTRL);
  assign pready  = psel & penable;

  always_comb
  begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (paddr)
      `LIE_OFS_EVT_SET,
      `LIE_OFS_EVT_CLR:
      begin
        rd_val = evt_q & mask_q & `LIE_EVT_IMPL; // [R4] [R5]
      end
      `LIE_OFS_EVT_MASK:
      begin
        rd_val = mask_q & `LIE_EVT_IMPL;
      end
      `LIE_OFS_EVT_RAW:
      begin
        rd_val = evt_q;
      end
      `LIE_OFS_CTRL:
      begin
        rd_val = {28'h000_0000, ctrl_q};
      end
      `LIE_OFS_XCVR:
      begin
        rd_val = 32'(xcvr_q) << `LIE_XCVR_LSB; // [R9]
      end
      default:
      begin
        mapped = 1'b0;
      end
    endcase
  end

  // Capturing at setup keeps prdata a flop with no wait state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr <= ~mapped;
    end
  end

  // General-purpose pins: three flops, a change counts when two agree
  assign gp_pin = {gp_input_b, gp_input_a};

  genvar gi;
  generate
    for (gi = 0; gi < `LIE_NUM_GP; gi++)
    begin : g_pin
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          gp_sync_q[gi] <= 3'h0;
          gp_pin_q[gi]  <= 1'b0;
        end
        else
        begin
          gp_sync_q[gi] <= {gp_sync_q[gi][1:0], gp_pin[gi]};
          // A one-cycle glitch between the last two flops is not taken
          if (gp_sync_q[gi][1] == gp_sync_q[gi][2])
          begin
            gp_pin_q[gi] <= gp_sync_q[gi][2];
          end
        end
      end
    end
  endgenerate

  // Event levels; each bit is set on the rising edge of its level
  assign gp_lvl   = (gp_pin_q[0] & ctrl_q[`LIE_CTRL_GP_A])
                  | (gp_pin_q[1] & ctrl_q[`LIE_CTRL_GP_B]); // [R6]
  assign late_lvl = ctrl_q[`LIE_CTRL_LATE_ACK]
                  & (src.rx_fifo_pending | src.resp_unit_busy | src.tardy_ack_sent); // [R8]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gp_lvl_q   <= 1'b0;
      late_lvl_q <= 1'b0;
      xcvr_lvl_q <= 1'b0;
    end
    else
    begin
      gp_lvl_q   <= gp_lvl;
      late_lvl_q <= late_lvl;
      xcvr_lvl_q <= src.xcvr_byte_valid;
    end
  end

  // Per-context death edge and record of the contexts at fault
  genvar gc;
  generate
    for (gc = 0; gc < `LIE_NUM_CTX; gc++)
    begin : g_ctx
      assign new_dead[gc] = src.ctx_dead[gc] & ~dead_lvl_q[gc];

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          dead_lvl_q[gc] <= 1'b0;
        end
        else
        begin
          dead_lvl_q[gc] <= src.ctx_dead[gc];
        end
      end

      // Forget the culprits only once software clears the fatal bit
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          dead_ctx_q[gc] <= 1'b0;
        end
        else
        begin
          dead_ctx_q[gc] <= evt_d[`LIE_BIT_FATAL] & (dead_ctx_q[gc] | new_dead[gc]);
        end
      end

      // Blocking of lower-bit events is left to the context logic
      assign ctx_evt_block[gc] = dead_ctx_q[gc] & evt_q[`LIE_BIT_FATAL]; // [R13]
    end
  endgenerate

  // Overlong cycle timer, running only while cycle root
  // A repeated start while running is ignored until the gap ends
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tmr_q     <= TMR_IDLE;
      tmr_cnt_q <= 16'h0000;
    end
    else
    begin
      unique case (tmr_q)
        TMR_IDLE:
        begin
          tmr_cnt_q <= 16'h0000;
          if (ctrl_q[`LIE_CTRL_ROOT] && src.cycle_start_tx)
          begin
            tmr_q <= TMR_RUN;
          end
        end
        TMR_RUN:
        begin
          if (!ctrl_q[`LIE_CTRL_ROOT] || src.subaction_gap_end || overlong)
          begin
            tmr_q <= TMR_IDLE;
          end
          else
          begin
            tmr_cnt_q <= tmr_cnt_q + 16'h0001;
          end
        end
      endcase
    end
  end

  assign overlong = (tmr_q == TMR_RUN) && ctrl_q[`LIE_CTRL_ROOT]
                  && !src.subaction_gap_end && (tmr_cnt_q == LIMIT); // [R10]

  // Control register; overlong drops the root role over any write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `LIE_CTRL_RESET;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_q <= pwdata[3:0];
      end
      if (overlong)
      begin
        ctrl_q[`LIE_CTRL_ROOT] <= 1'b0; // [R11]
      end
    end
  end

  assign cycle_root_role = ctrl_q[`LIE_CTRL_ROOT];

  // Unimplemented mask bits stay 0, so they can never raise irq
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_q <= 32'h0000_0000;
    end
    else if (wr_mask)
    begin
      mask_q <= pwdata & `LIE_EVT_IMPL;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xcvr_q <= 8'h00;
    end
    // Byte captured on the edge that sets its event bit
    else if (src.xcvr_byte_valid && !xcvr_lvl_q)
    begin
      xcvr_q <= src.xcvr_byte; // [R9]
    end
  end

  // Event register
  always_comb
  begin
    // Software-only bit has no source here; only the ports move it
    hw_set                     = 32'h0000_0000;
    hw_set[`LIE_BIT_GP_INPUT]  = gp_lvl & ~gp_lvl_q; // [R1] [R6]
    hw_set[`LIE_BIT_LATE_ACK]  = late_lvl & ~late_lvl_q; // [R1] [R8]
    hw_set[`LIE_BIT_XCVR_BYTE] = src.xcvr_byte_valid & ~xcvr_lvl_q; // [R9]
    hw_set[`LIE_BIT_OVERLONG]  = overlong; // [R10]
    hw_set[`LIE_BIT_FATAL]     = |new_dead; // [R12]
    hw_set                     = hw_set & `LIE_EVT_HW; // [R7] [R14]
  end

  assign sw_set = wr_set ? (pwdata & `LIE_EVT_IMPL) : 32'h0000_0000; // [R2] [R5]
  assign sw_clr = wr_clr ? (pwdata & `LIE_EVT_IMPL) : 32'h0000_0000; // [R3]

  // Set terms are ORed after the clear so a same-cycle event survives
  assign evt_d = ((evt_q & ~sw_clr) | sw_set | hw_set) & `LIE_EVT_IMPL; // [R16] [R5]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt_q <= 32'h0000_0000;
    end
    else
    begin
      evt_q <= evt_d; // [R1] [R3]
    end
  end

  // Combinational AND-OR of the evt_q and mask_q flops; irq itself is not registered
  assign irq = |(evt_q & mask_q); // [R15]

endmodule

`default_nettype wire

// [verification/lie_evt_checker.sv]
// Assertions on the APB, interrupt and cycle timer outputs of lie_evt.
// Assumes binding into lie_evt; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module lie_evt_checker
  import lie_pkg::*;
#(
  parameter int OVERLONG_CYC = 20
)
(
  input wire logic        pclk,            // Clock
  input wire logic        presetn,         // Reset
  input wire logic        psel,            // Select
  input wire logic        penable,         // Access
  input wire logic        pwrite,          // Direction
  input wire logic [7:0]  paddr,           // Address
  input wire logic [31:0] pwdata,          // Write data
  input wire logic        pready,          // Ready
  input wire logic [31:0] prdata,          // Read data
  input wire logic        pslverr,         // Error
  input wire lie_src_s    src,             // Sources
  input wire logic        irq,             // Interrupt
  input wire logic        cycle_root_role, // Root role
  input wire logic [3:0]  ctx_evt_block    // Blocked contexts
);
  logic        wa;
  logic [15:0] cnt_q;
  assign wa = psel && penable && pwrite;
  // Cycles since a cycle start while still root
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cnt_q <= 16'h0;
    else if (src.cycle_start_tx && cycle_root_role)
      cnt_q <= 16'h1;
    else if (cnt_q != 16'h0)
      cnt_q <= (src.subaction_gap_end || !cycle_root_role) ? 16'h0 : cnt_q + 16'h1;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && penable |-> pready; endproperty
  property p_reserved_bits; psel && penable |-> !prdata[31] && !prdata[28]; endproperty
  property p_wr0; wa |-> prdata == 32'h0; endproperty
  property p_err;
    psel && penable |-> pslverr == !(paddr inside {8'h80, 8'h84, 8'h88, 8'h8c, 8'h90, 8'h94});
  endproperty
  property p_dead; $rose(src.ctx_dead[1]) |=> ctx_evt_block[1]; endproperty
  property p_unblk;
    wa && paddr == 8'h84 && pwdata[24] && $stable(src.ctx_dead) |=> ctx_evt_block == 4'h0;
  endproperty
  property p_ovl; cnt_q == 16'(OVERLONG_CYC + 2) |-> !cycle_root_role; endproperty
  property p_msk; wa && paddr == 8'h88 && pwdata == 32'h0 |=> !irq; endproperty
  property p_fell; $fell(irq) |-> $past(wa); endproperty
  a_rdy: assert property (p_rdy) else $error("pready low in access");
  a_reserved_bits: assert property (p_reserved_bits) else $error("reserved bit read as 1");
  a_wr0: assert property (p_wr0) else $error("read data not 0 on write");
  a_err: assert property (p_err) else $error("pslverr wrong for address");
  a_dead: assert property (p_dead) else $error("dead context not blocked");
  a_unblk: assert property (p_unblk) else $error("block kept after clear");
  a_ovl: assert property (p_ovl) else $error("root role kept on overlong");
  a_msk: assert property (p_msk) else $error("irq high with zero mask");
  a_fell: assert property (p_fell) else $error("irq fell without a write");
  c_irq: cover property ($rose(irq));
  c_ovl: cover property (cnt_q == 16'(OVERLONG_CYC + 2));
  c_blk: cover property (ctx_evt_block != 4'h0);
endmodule
bind lie_evt lie_evt_checker #(.OVERLONG_CYC(OVERLONG_CYC)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .src(src), .irq(irq), .cycle_root_role(cycle_root_role), .ctx_evt_block(ctx_evt_block)
);
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for lie_evt, driven over APB.
// Assumes lie_pkg, lie_evt and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb
  import lie_pkg::*;
;
  localparam int N = 20;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        gpa     = 1'b0;
  logic        gpb     = 1'b0;
  lie_src_s    src     = '0;
  logic        pready, pslverr, irq, role;
  logic [31:0] prdata;
  logic [3:0]  blk;
  int          error_cnt = 0;
  int          n_tests   = 0;
  always #5 pclk = ~pclk;
  lie_evt #(.OVERLONG_CYC(N)) u_lie_evt (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .gp_input_a(gpa), .gp_input_b(gpb), .src(src), .irq(irq),
    .cycle_root_role(role), .ctx_evt_block(blk)
  );
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Idle edge at the end keeps back-to-back calls from double driving psel
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [32:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    // Response taken at the edge that sees pready high
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    logic [32:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic pulse_start;
    src.cycle_start_tx <= 1'b1;
    cyc(1);
    src.cycle_start_tx <= 1'b0;
  endtask
  task automatic done(input string s);
    $display("test %s finished, mismatches %0d", s, error_cnt);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #100us;
    error_cnt++;
    print_verdict();
  end
  initial
  begin
    cyc(8);
    presetn <= 1'b1;
    cyc(1);
    rd(8'h90, 33'h0);
    rd(8'h8c, 33'h0);
    rd(8'h00, 33'h1_0000_0000);
    done("reset");
    wr(8'h88, 32'hffff_ffff);
    rd(8'h88, 33'h0_6f00_0000);
    wr(8'h80, 32'hffff_ffff);
    rd(8'h8c, 33'h0_6f00_0000);
    chk(irq, 33'h1);
    wr(8'h88, 32'h0);
    chk(irq, 33'h0);
    wr(8'h88, 32'h2000_0000);
    rd(8'h84, 33'h0_2000_0000);
    wr(8'h84, 32'hdfff_ffff);
    rd(8'h8c, 33'h0_2000_0000);
    wr(8'h84, 32'h2000_0000);
    rd(8'h8c, 33'h0);
    done("software");
    src.xcvr_byte <= 8'ha5;
    src.xcvr_byte_valid <= 1'b1;
    cyc(2);
    rd(8'h8c, 33'h0_0400_0000);
    rd(8'h94, 33'h0_00a5_0000);
    wr(8'h84, 32'h0400_0000);
    rd(8'h8c, 33'h0);
    src.xcvr_byte_valid <= 1'b0;
    src.rx_fifo_pending <= 1'b1;
    cyc(2);
    src.rx_fifo_pending <= 1'b0;
    rd(8'h8c, 33'h0);
    wr(8'h90, 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      {src.rx_fifo_pending, src.resp_unit_busy, src.tardy_ack_sent} <= 3'(3'b100 >> i);
      cyc(2);
      {src.rx_fifo_pending, src.resp_unit_busy, src.tardy_ack_sent} <= 3'b000;
      rd(8'h8c, 33'h0_0800_0000);
      wr(8'h84, 32'h0800_0000);
    end
    done("hardware");
    wr(8'h90, 32'h2);
    gpb <= 1'b1;
    cyc(6);
    rd(8'h8c, 33'h0);
    gpa <= 1'b1;
    cyc(6);
    rd(8'h8c, 33'h0_4000_0000);
    gpa <= 1'b0;
    gpb <= 1'b0;
    wr(8'h84, 32'h4000_0000);
    done("gp");
    wr(8'h90, 32'h8);
    chk(role, 33'h1);
    pulse_start();
    cyc(5);
    src.subaction_gap_end <= 1'b1;
    cyc(1);
    src.subaction_gap_end <= 1'b0;
    cyc(N + 4);
    rd(8'h8c, 33'h0);
    pulse_start();
    cyc(N + 4);
    chk(role, 33'h0);
    rd(8'h8c, 33'h0_0200_0000);
    wr(8'h84, 32'h0200_0000);
    done("overlong");
    src.ctx_dead <= 4'h2;
    cyc(2);
    rd(8'h8c, 33'h0_0100_0000);
    chk(blk, 33'h2);
    wr(8'h84, 32'h0100_0000);
    chk(blk, 33'h0);
    src.ctx_dead <= 4'h0;
    done("fatal");
    // Byte event rises on the very edge that the clear write lands
    fork
      wr(8'h84, 32'h0400_0000);
      begin
        cyc(1);
        src.xcvr_byte_valid <= 1'b1;
      end
    join
    rd(8'h8c, 33'h0_0400_0000);
    src.xcvr_byte_valid <= 1'b0;
    wr(8'h84, 32'h0400_0000);
    rd(8'h8c, 33'h0);
    done("set wins");
    print_verdict();
  end
endmodule
`default_nettype wire
